/* logic/core_memory_bank_datapath.sv */
// one core memory bank: address and word hold registers with bus gating
//
// Operation
// - select decoded from address bits 1-3 (4K) or 1-4 (2K)
// - address bits 4 through 9 pick Y drive lines
// - address bits 10 through 15 pick X drive lines
// - with both read phases, sample pulses gate stored data onto sense lines
// - while sensing, sense line value forced into word hold register over any word hold load
// - word hold register feeds both I/O and core bus gates
// - otherwise word hold loads from mux of I/O bus or result bus
// - mux value written to word hold only on word hold load
// - address register takes mux bits 1 to 15 on address hold load
// - no memory operation unless bank selected
// - write only when write phase meets select; makes strobes, enable
// - write-current enable turns on drive currents for write half
// - suppress strobes pass inverted word bits to inhibit drivers
// - inhibited bit stays cleared, stored word equals word hold register
// - io source select makes mux take the I/O data bus
// - io bus drive low puts selected bank word on I/O bus
// - core bus drivers off disables every bank's core bus drivers
`timescale 1ns/10ps
`default_nettype none
module core_memory_bank_datapath #(
    parameter bit BANK_4K = 1'b1,
    parameter logic [3:0] BANK_ID = 4'h0
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    // processor controls, synchronous to ref_clk_in
    input wire core_bank_pkg::mem_ctrl_t ctrl_in,
    // data buses into the mux
    input wire logic [core_bank_pkg::WORD_W-1:0] cpu_result_bus_in,
    input wire logic [core_bank_pkg::WORD_W-1:0] io_data_line_in,
    // stored word read from the core array
    input wire logic [core_bank_pkg::WORD_W-1:0] core_word_in,
    // bus outputs
    output logic [core_bank_pkg::WORD_W-1:0] io_data_line_out,
    output logic io_data_line_oe_out,
    output logic [core_bank_pkg::WORD_W-1:0] core_bus_line_out,
    output logic core_bus_line_oe_out,
    // array drive
    output logic [core_bank_pkg::AXIS_W-1:0] y_select_out,
    output logic [core_bank_pkg::AXIS_W-1:0] x_select_out,
    output logic bank_selected_out,
    output logic [core_bank_pkg::WORD_W-1:0] sense_line_out,
    output core_bank_pkg::write_drive_t write_drive_out,
    output logic [core_bank_pkg::WORD_W-1:0] address_hold_out,
    output logic [core_bank_pkg::WORD_W-1:0] word_hold_out
);
    localparam int W = core_bank_pkg::WORD_W;
    localparam int A = core_bank_pkg::ADDR_W;

    logic [W-1:0] word_hold_reg;
    logic [A-1:0] address_hold_reg;
    logic [W-1:0] mux_out;
    logic bank_select;
    logic sense_active;
    logic write_active;
    logic [W-1:0] sense_line;

    // bit n of the 15-bit address (1..15) sits at index A-n
    function automatic logic abit(input logic [A-1:0] a, input int n);
        abit = a[A-n];
    endfunction : abit

    always_comb begin
        if (ctrl_in.io_source_select) begin
            mux_out = io_data_line_in;
        end else begin
            mux_out = cpu_result_bus_in;
        end
    end

    // select compares the high address bits against the bank number
    always_comb begin
        if (BANK_4K) begin
            bank_select = {abit(address_hold_reg, 1), abit(address_hold_reg, 2),
                abit(address_hold_reg, 3)} == BANK_ID[2:0];
        end else begin
            bank_select = {abit(address_hold_reg, 1), abit(address_hold_reg, 2),
                abit(address_hold_reg, 3),
                abit(address_hold_reg, 4)} == BANK_ID;
        end
    end

    // a read needs both phases and a sample pulse, gated by select
    assign sense_active = bank_select && ctrl_in.read_phase_one &&
        ctrl_in.read_phase_two && (|ctrl_in.sample);
    assign sense_line = sense_active ? core_word_in : '0;
    assign write_active = bank_select && ctrl_in.write_phase;

    // address register: mux bits 1 to 15 are the low 15 bits
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            address_hold_reg <= core_bank_pkg::ADDR_RST;
        end else if (ctrl_in.address_hold_load) begin
            address_hold_reg <= mux_out[A-1:0];
        end
    end

    // sense capture is a jam set, so it wins over a concurrent load
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            word_hold_reg <= core_bank_pkg::WORD_RST;
        end else if (sense_active) begin
            word_hold_reg <= sense_line;
        end else if (ctrl_in.word_hold_load) begin
            word_hold_reg <= mux_out;
        end
    end

    // registered bus drive
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            io_data_line_out <= '0;
            io_data_line_oe_out <= 1'b0;
            core_bus_line_out <= '0;
            core_bus_line_oe_out <= 1'b0;
        end else begin
            io_data_line_out <= word_hold_reg;
            io_data_line_oe_out <= bank_select && !ctrl_in.io_bus_drive_n;
            core_bus_line_out <= word_hold_reg;
            core_bus_line_oe_out <= bank_select &&
                !ctrl_in.core_bus_drivers_off;
        end
    end

    // registered array drive
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            y_select_out <= '0;
            x_select_out <= '0;
            bank_selected_out <= 1'b0;
            sense_line_out <= '0;
            write_drive_out <= '0;
            address_hold_out <= '0;
            word_hold_out <= '0;
        end else begin
            y_select_out <= address_hold_reg[A-core_bank_pkg::Y_LO -:
                core_bank_pkg::AXIS_W];
            x_select_out <= address_hold_reg[A-core_bank_pkg::X_LO -:
                core_bank_pkg::AXIS_W];
            bank_selected_out <= bank_select;
            sense_line_out <= sense_line;
            write_drive_out.write_current_en <= write_active;
            write_drive_out.suppress_gate <= {2{write_active}};
            // inverted word gated by strobe: ones get no inhibit
            write_drive_out.suppress_bit <= write_active ?
                ~word_hold_reg : '0;
            address_hold_out <= {1'b0, address_hold_reg};
            word_hold_out <= word_hold_reg;
        end
    end

    // all checks share the one clock and the async reset
    default clocking chk_clk @(posedge ref_clk_in);
    endclocking
    default disable iff (!resetn_in);

    chk_addr_load: assert property (
        ctrl_in.address_hold_load
        |=> address_hold_reg == $past(mux_out[A-1:0]))
        else $error("address hold load mismatch");
    chk_word_load: assert property (
        ctrl_in.word_hold_load && !sense_active
        |=> word_hold_reg == $past(mux_out))
        else $error("word hold load mismatch");
    chk_word_hold: assert property (
        !ctrl_in.word_hold_load && !sense_active
        |=> $stable(word_hold_reg))
        else $error("word hold changed without cause");
    chk_sense_jam: assert property (
        sense_active
        |=> word_hold_reg == $past(core_word_in))
        else $error("sense capture missed");
    chk_write_gate: assert property (
        write_drive_out.write_current_en
        |-> $past(write_active))
        else $error("write current without select and phase");
    chk_inhibit_bits: assert property (
        write_active
        |=> write_drive_out.suppress_bit == ~$past(word_hold_reg))
        else $error("suppress bits not inverted word");
    chk_io_drive: assert property (
        io_data_line_oe_out
        |-> $past(!ctrl_in.io_bus_drive_n && bank_select))
        else $error("io bus driven without request");
    chk_core_off: assert property (
        ctrl_in.core_bus_drivers_off
        |=> !core_bus_line_oe_out)
        else $error("core bus driven while off");
    chk_no_select: assert property (
        !bank_select
        |=> !write_drive_out.write_current_en && sense_line_out == '0)
        else $error("operation while unselected");
endmodule : core_memory_bank_datapath
`default_nettype wire

/* logic/core_bank_pkg.sv */
// shared constants and carrier types for the core memory bank
package core_bank_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 15;
    localparam int AXIS_W = 6;
    // address_hold_reg bit numbering: bit 1 is msb of 15-bit field
    localparam int SEL_LO_4K = 1;
    localparam int SEL_HI_4K = 3;
    localparam int SEL_LO_2K = 1;
    localparam int SEL_HI_2K = 4;
    localparam int Y_LO = 4;
    localparam int Y_HI = 9;
    localparam int X_LO = 10;
    localparam int X_HI = 15;
    localparam int NUM_STROBES = 4;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;

    // processor-side memory controls
    typedef struct packed {
        logic word_hold_load;
        logic address_hold_load;
        logic io_source_select;
        logic io_bus_drive_n;
        logic core_bus_drivers_off;
        logic read_phase_one;
        logic read_phase_two;
        logic [NUM_STROBES-1:0] sample;
        logic write_phase;
    } mem_ctrl_t;

    // write drive toward the array
    typedef struct packed {
        logic write_current_en;
        logic [1:0] suppress_gate;
        logic [WORD_W-1:0] suppress_bit;
    } write_drive_t;
endpackage : core_bank_pkg

/* tb/core_array_model.sv */
// core array model: destructive sense, inhibit write-back
`timescale 1ns/10ps
`default_nettype none
module core_array_model (
    // clock and sense request
    input wire logic ref_clk_in,
    input wire logic sense_in,
    // drive lines from the bank
    input wire logic [5:0] y_select_in,
    input wire logic [5:0] x_select_in,
    input wire core_bank_pkg::write_drive_t write_drive_in,
    // stored word toward the bank
    output logic [15:0] core_word_out
);
    logic [15:0] cells [4096];
    initial begin
        foreach (cells[k]) cells[k] = 16'h0000;
    end
    assign core_word_out = cells[{y_select_in, x_select_in}];
    always @(posedge ref_clk_in) begin
        if (write_drive_in.write_current_en) begin
            // inhibited bits stay cleared, so cell takes the word
            cells[{y_select_in, x_select_in}] <= ~write_drive_in.suppress_bit;
        end else if (sense_in) begin
            // sensing clears the cores until written back
            cells[{y_select_in, x_select_in}] <= 16'h0000;
        end
    end
endmodule : core_array_model
`default_nettype wire

/* tb/core_memory_bank_datapath_bench.sv */
// self-checking bench for the core memory bank
`timescale 1ns/10ps
`default_nettype none
module core_memory_bank_datapath_bench;
    logic ref_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    core_bank_pkg::mem_ctrl_t ctrl = '0;
    core_bank_pkg::mem_ctrl_t c;
    core_bank_pkg::write_drive_t wd;
    logic [15:0] rb = 16'h0000;
    logic [15:0] ib = 16'h0000;
    logic [15:0] cw, io_q, core_q, sns, aq, wq, w, r, i;
    logic io_oe, core_oe, sel, es;
    logic [5:0] yq, xq;
    // outputs that stand only for the edge right after the strobe
    core_bank_pkg::write_drive_t wd_e;
    logic [15:0] sns_e;
    logic [14:0] a;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    core_memory_bank_datapath dut (.ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in), .ctrl_in(ctrl), .cpu_result_bus_in(rb),
        .io_data_line_in(ib), .core_word_in(cw), .io_data_line_out(io_q),
        .io_data_line_oe_out(io_oe), .core_bus_line_out(core_q),
        .core_bus_line_oe_out(core_oe), .y_select_out(yq),
        .x_select_out(xq), .bank_selected_out(sel), .sense_line_out(sns),
        .write_drive_out(wd), .address_hold_out(aq), .word_hold_out(wq));
    core_array_model pm (.ref_clk_in(ref_clk_in),
        .sense_in(ctrl.read_phase_one & ctrl.read_phase_two & sel),
        .y_select_in(yq), .x_select_in(xq), .write_drive_in(wd),
        .core_word_out(cw));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict
    // one strobe cycle; bus-drive levels persist, outputs lag two edges
    // write drive and sense lines are snapshotted one edge after the strobe
    // controls come as one phase word, as the timing logic builds them
    task automatic op(input logic [15:0] res, input logic [15:0] io);
        core_bank_pkg::mem_ctrl_t idle;
        idle = '0;
        idle.io_bus_drive_n = c.io_bus_drive_n;
        idle.core_bus_drivers_off = c.core_bus_drivers_off;
        @(posedge ref_clk_in);
        ctrl <= c;
        rb <= res;
        ib <= io;
        @(posedge ref_clk_in);
        ctrl <= idle;
        #1;
        wd_e = wd;
        sns_e = sns;
        @(posedge ref_clk_in);
        #1;
    endtask : op
    initial begin
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(32'h1ad69422));
        repeat (20) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        repeat (150) begin
            a = 15'($urandom);
            // mostly selected, sometimes another bank
            if ($urandom_range(0, 3) != 0) a[14:12] = 3'h0;
            es = (a[14:12] == 3'h0);
            c = '0;
            c.io_bus_drive_n = 1'($urandom);
            c.core_bus_drivers_off = 1'($urandom);
            c.io_source_select = 1'($urandom);
            c.address_hold_load = 1'b1;
            r = 16'($urandom);
            i = 16'($urandom);
            if (c.io_source_select) i[14:0] = a;
            else r[14:0] = a;
            op(r, i);
            check(aq, {1'b0, a});
            check({4'h0, yq, xq}, {4'h0, a[11:0]});
            check(16'(sel), 16'(es));
            w = 16'($urandom);
            c.address_hold_load = 1'b0;
            if (es) begin
                c.word_hold_load = 1'b1;
                c.io_source_select = 1'($urandom);
                r = c.io_source_select ? ~w : w;
                op(r, ~r);
                check(wq, w);
                check({14'h0, io_oe, core_oe},
                    {14'h0, !c.io_bus_drive_n, !c.core_bus_drivers_off});
                if (io_oe === 1'b1) check(io_q, w);
                if (core_oe === 1'b1) check(core_q, w);
            end
            c.word_hold_load = 1'b0;
            c.write_phase = 1'b1;
            op(rb, ib);
            check(16'(wd_e.write_current_en), 16'(es));
            check(16'(wd_e.suppress_gate), es ? 16'h0003 : 16'h0000);
            check(wd_e.suppress_bit, es ? ~w : 16'h0000);
            check(16'(wd.write_current_en), 16'h0000);
            c.write_phase = 1'b0;
            if (es) begin
                // overwrite the hold register so the read must refill it
                c.word_hold_load = 1'b1;
                c.io_source_select = 1'b0;
                op(~w, w);
                c.word_hold_load = 1'($urandom);
                {c.read_phase_one, c.read_phase_two} = 2'b11;
                c.sample = 4'hf;
                op(r, ~r);
                check(wq, w);
                check(sns_e, w);
                check(sns, 16'h0000);
            end
        end
        give_verdict();
    end
endmodule : core_memory_bank_datapath_bench
`default_nettype wire
